// [common/tcmp_pkg.sv]
// How it works
// - Counter and compare value compared always; equality sets match flag next tick.
// - Match flag with interrupt enable raises interrupt; acknowledge clears the flag.
// - Writing one to the match flag bit clears it; zero does nothing.
// - PWM modes buffer compare value until top or bottom; other modes bypass.
// - CPU compare accesses hit buffer when buffering, live register otherwise.
// - Force strobe in non-PWM modes acts on output only, no flag or clear.
// - Counter write blocks compare matches during the next timer tick.
// - Nonzero output mode makes waveform output replace port data; direction unchanged.
// - Output mode zero leaves the waveform output register unchanged on matches.
// - Output mode is not buffered; takes effect at the first following match.
// - Waveform output register keeps its value across waveform mode changes.
// - Counting depends only on waveform mode; output mode never alters counting.
// - Mode 0 always increments, never clears on match, wraps 0xFF to 0x00.
// - Normal mode overflow flag sets when count becomes zero; acknowledge clears it.
// - Mode 2 clears counter the tick after it equals the compare value.
// - Compare value written below count in mode 2: count wraps through 0xFF first.
// - Toggle mode in mode 2 toggles output on every match.
// - Mode 2 overflow flag sets when counter passes from maximum to 0x00.
// - CPU counter write beats any clear or count in the same cycle.
// - Clock source zero stops the timer; CPU access still works.
// - Bottom is 0x00, maximum 0xFF, top is maximum or compare value by mode.
package tcmp_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_COUNT = 12'h004;
  localparam logic [11:0] ADDR_COMPARE = 12'h008;
  localparam logic [11:0] ADDR_FLAGS = 12'h00C;
  localparam logic [11:0] ADDR_IRQEN = 12'h010;
  localparam logic [11:0] ADDR_FORCE = 12'h014;
  localparam logic [11:0] ADDR_PORT = 12'h018;
  localparam int CTRL_WGM_LSB = 0;
  localparam int CTRL_COM_LSB = 2;
  localparam int CTRL_CS_LSB = 4;
  localparam int FLAG_MATCH_BIT = 0;
  localparam int FLAG_OVF_BIT = 1;
  localparam int PORT_DATA_BIT = 0;
  localparam int PORT_DIR_BIT = 1;
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAXV = 8'hFF;
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PCPWM = 2'h1;
  localparam logic [1:0] WGM_CLEAR = 2'h2;
  localparam logic [1:0] WGM_FAST = 2'h3;
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [2:0] clock_source_sel;
    logic [1:0] compare_output_mode;
    logic [1:0] waveform_mode_sel;
  } tcmp_ctrl_t;

  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } tcmp_wreq_t;
endpackage

// [core/tcmp_tick_div.sv]
`timescale 1ns/1ps
module tcmp_tick_div (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] sel,
  output logic tick
);
  typedef struct packed {
    logic [9:0] cnt;
  } tcmp_div_state_t;
  tcmp_div_state_t state_reg;
  tcmp_div_state_t state_next;
  logic [9:0] mask;

  always_comb begin
    unique case (sel)
      3'h1: mask = 10'h000;
      3'h2: mask = 10'h007;
      3'h3: mask = 10'h01F;
      3'h4: mask = 10'h03F;
      3'h5: mask = 10'h07F;
      3'h6: mask = 10'h0FF;
      3'h7: mask = 10'h3FF;
      default: mask = 10'h000;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.cnt = 10'(state_reg.cnt + 10'h001);
    if (sel == tcmp_pkg::CS_STOP) begin
      state_next.cnt = 10'h000;
    end
  end

  // Stop selection gives no tick
  assign tick = (sel != tcmp_pkg::CS_STOP) && ((state_reg.cnt & mask) == 10'h000);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// [core/tcmp_apb_slave.sv]
`timescale 1ns/1ps
module tcmp_apb_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] rd_word,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output tcmp_pkg::tcmp_wreq_t wreq,
  output logic [11:0] rd_addr
);
  typedef struct packed {
    logic [31:0] rdata;
  } tcmp_apb_state_t;
  tcmp_apb_state_t state_reg;
  tcmp_apb_state_t state_next;
  logic mapped;

  assign mapped = (paddr <= tcmp_pkg::ADDR_PORT) && (paddr[1:0] == 2'h0);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign rd_addr = paddr;
  assign prdata = state_reg.rdata;
  assign wreq.wr = psel && penable && pwrite && mapped;
  assign wreq.addr = paddr;
  assign wreq.wdata = pwdata;

  // Read data captured in setup so it is registered at access
  always_comb begin
    state_next = state_reg;
    if (psel && !penable) begin
      state_next.rdata = (!pwrite && mapped) ? rd_word : tcmp_pkg::RESET_WORD;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// [core/tcmp_timer.sv]
`timescale 1ns/1ps
module tcmp_timer (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MATCH_IRQ_ACK,
  input wire logic OVF_IRQ_ACK,
  output logic MATCH_IRQ,
  output logic OVF_IRQ,
  output logic PIN_OUT,
  output logic PIN_OE
);
  typedef struct packed {
    tcmp_pkg::tcmp_ctrl_t ctrl;
    logic [7:0] count_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buf;
    logic compare_match_flag;
    logic overflow_flag;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic waveform_output;
    logic port_data;
    logic output_pin_direction;
    logic block_match;
    logic count_down;
    logic pin_out;
    logic pin_oe;
  } tcmp_state_t;

  tcmp_state_t state_reg;
  tcmp_state_t state_next;
  tcmp_pkg::tcmp_wreq_t wreq;
  logic [11:0] rd_addr;
  logic [31:0] rd_word;
  logic tick;
  logic pwm;
  logic match;
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;
  logic wr_irqen;
  logic wr_force;
  logic wr_port;
  logic [1:0] wgm;
  logic [1:0] com;
  logic at_top;
  logic at_bottom;
  logic wave_event;
  logic wave_up;

  tcmp_apb_slave u_apb (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .rd_word(rd_word),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .wreq(wreq),
    .rd_addr(rd_addr)
  );

  tcmp_tick_div u_div (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .sel(state_reg.ctrl.clock_source_sel),
    .tick(tick)
  );

  assign wgm = state_reg.ctrl.waveform_mode_sel;
  assign com = state_reg.ctrl.compare_output_mode;
  assign pwm = (wgm == tcmp_pkg::WGM_PCPWM) || (wgm == tcmp_pkg::WGM_FAST);
  assign wr_ctrl = wreq.wr && (wreq.addr == tcmp_pkg::ADDR_CTRL);
  assign wr_count = wreq.wr && (wreq.addr == tcmp_pkg::ADDR_COUNT);
  assign wr_compare = wreq.wr && (wreq.addr == tcmp_pkg::ADDR_COMPARE);
  assign wr_flags = wreq.wr && (wreq.addr == tcmp_pkg::ADDR_FLAGS);
  assign wr_irqen = wreq.wr && (wreq.addr == tcmp_pkg::ADDR_IRQEN);
  assign wr_force = wreq.wr && (wreq.addr == tcmp_pkg::ADDR_FORCE) && wreq.wdata[0];
  assign wr_port = wreq.wr && (wreq.addr == tcmp_pkg::ADDR_PORT);

  // Live comparison, masked for a tick after a counter write
  assign match = (state_reg.count_value == state_reg.compare_value) && !state_reg.block_match;
  assign at_bottom = state_reg.count_value == tcmp_pkg::BOTTOM;
  assign at_top = (wgm == tcmp_pkg::WGM_CLEAR) ?
                  (state_reg.count_value == state_reg.compare_value) :
                  (state_reg.count_value == tcmp_pkg::MAXV);

  // Register reads
  always_comb begin
    rd_word = tcmp_pkg::RESET_WORD;
    unique case (rd_addr)
      tcmp_pkg::ADDR_CTRL: rd_word[6:0] = state_reg.ctrl;
      tcmp_pkg::ADDR_COUNT: rd_word[7:0] = state_reg.count_value;
      tcmp_pkg::ADDR_COMPARE: rd_word[7:0] = pwm ? state_reg.compare_buf :
                                               state_reg.compare_value;
      tcmp_pkg::ADDR_FLAGS: begin
        rd_word[tcmp_pkg::FLAG_MATCH_BIT] = state_reg.compare_match_flag;
        rd_word[tcmp_pkg::FLAG_OVF_BIT] = state_reg.overflow_flag;
      end
      tcmp_pkg::ADDR_IRQEN: begin
        rd_word[tcmp_pkg::FLAG_MATCH_BIT] = state_reg.compare_irq_enable;
        rd_word[tcmp_pkg::FLAG_OVF_BIT] = state_reg.overflow_irq_enable;
      end
      tcmp_pkg::ADDR_PORT: begin
        rd_word[tcmp_pkg::PORT_DATA_BIT] = state_reg.port_data;
        rd_word[tcmp_pkg::PORT_DIR_BIT] = state_reg.output_pin_direction;
        rd_word[2] = state_reg.waveform_output;
      end
      default: rd_word = tcmp_pkg::RESET_WORD;
    endcase
  end

  // Waveform action selection
  always_comb begin
    wave_event = 1'b0;
    wave_up = state_reg.waveform_output;
    if (!pwm) begin
      wave_event = (tick && match) || wr_force;
      unique case (com)
        tcmp_pkg::COM_TOGGLE: wave_up = !state_reg.waveform_output;
        tcmp_pkg::COM_CLEAR: wave_up = 1'b0;
        tcmp_pkg::COM_SET: wave_up = 1'b1;
        default: wave_up = state_reg.waveform_output;
      endcase
    end else if (wgm == tcmp_pkg::WGM_FAST) begin
      if (tick && match) begin
        wave_event = 1'b1;
        unique case (com)
          tcmp_pkg::COM_TOGGLE: wave_up = !state_reg.waveform_output;
          tcmp_pkg::COM_CLEAR: wave_up = 1'b0;
          tcmp_pkg::COM_SET: wave_up = 1'b1;
          default: wave_up = state_reg.waveform_output;
        endcase
      end else if (tick && at_top) begin
        wave_event = com[1];
        wave_up = !com[0];
      end
    end else if (tick && match) begin
      wave_event = com[1];
      wave_up = com[0] ^ state_reg.count_down;
    end
  end

  always_comb begin
    state_next = state_reg;
    if (wr_ctrl) begin
      state_next.ctrl = wreq.wdata[6:0];
    end
    if (wr_irqen) begin
      state_next.compare_irq_enable = wreq.wdata[tcmp_pkg::FLAG_MATCH_BIT];
      state_next.overflow_irq_enable = wreq.wdata[tcmp_pkg::FLAG_OVF_BIT];
    end
    if (wr_port) begin
      state_next.port_data = wreq.wdata[tcmp_pkg::PORT_DATA_BIT];
      state_next.output_pin_direction = wreq.wdata[tcmp_pkg::PORT_DIR_BIT];
    end
    if (wr_compare) begin
      if (pwm) begin
        state_next.compare_buf = wreq.wdata[7:0];
      end else begin
        state_next.compare_value = wreq.wdata[7:0];
        state_next.compare_buf = wreq.wdata[7:0];
      end
    end
    // Flag clears first so a hardware set below wins
    if (wr_flags && wreq.wdata[tcmp_pkg::FLAG_MATCH_BIT]) begin
      state_next.compare_match_flag = 1'b0;
    end
    if (wr_flags && wreq.wdata[tcmp_pkg::FLAG_OVF_BIT]) begin
      state_next.overflow_flag = 1'b0;
    end
    if (MATCH_IRQ_ACK) begin
      state_next.compare_match_flag = 1'b0;
    end
    if (OVF_IRQ_ACK) begin
      state_next.overflow_flag = 1'b0;
    end
    if (tick) begin
      state_next.block_match = 1'b0;
      if (match) begin
        state_next.compare_match_flag = 1'b1;
      end
      // Counting sequence set by waveform mode only
      unique case (wgm)
        tcmp_pkg::WGM_CLEAR: begin
          state_next.count_value = (state_reg.count_value == state_reg.compare_value) ?
                                   tcmp_pkg::BOTTOM :
                                   8'(state_reg.count_value + 8'h01);
          if (state_reg.count_value == tcmp_pkg::MAXV) begin
            state_next.overflow_flag = 1'b1;
          end
        end
        tcmp_pkg::WGM_PCPWM: begin
          if (state_reg.count_down) begin
            state_next.count_value = 8'(state_reg.count_value - 8'h01);
            state_next.count_down = state_reg.count_value != 8'h01;
          end else begin
            state_next.count_value = 8'(state_reg.count_value + 8'h01);
            state_next.count_down = state_reg.count_value == 8'hFE;
          end
          if (at_bottom) begin
            state_next.overflow_flag = 1'b1;
            state_next.compare_value = state_reg.compare_buf;
          end
        end
        default: begin
          state_next.count_value = 8'(state_reg.count_value + 8'h01);
          if (state_reg.count_value == tcmp_pkg::MAXV) begin
            state_next.overflow_flag = 1'b1;
            if (wgm == tcmp_pkg::WGM_FAST) begin
              state_next.compare_value = state_reg.compare_buf;
            end
          end
        end
      endcase
    end
    if (wave_event) begin
      state_next.waveform_output = wave_up;
    end
    if (!pwm) begin
      state_next.count_down = 1'b0;
    end
    if (wr_count) begin
      state_next.count_value = wreq.wdata[7:0];
      state_next.block_match = 1'b1;
    end
    state_next.pin_out = (com != tcmp_pkg::COM_NONE) ? state_next.waveform_output :
                         state_next.port_data;
    state_next.pin_oe = state_next.output_pin_direction;
  end

  assign MATCH_IRQ = state_reg.compare_match_flag && state_reg.compare_irq_enable;
  assign OVF_IRQ = state_reg.overflow_flag && state_reg.overflow_irq_enable;
  assign PIN_OUT = state_reg.pin_out;
  assign PIN_OE = state_reg.pin_oe;

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// [tb/tcmp_pin_model.sv]
`timescale 1ns/1ps
module tcmp_pin_model (
  input wire logic drv,
  input wire logic oe,
  output logic pad
);
  // Pad with pull-up; released pad reads high
  assign pad = oe ? drv : 1'b1;
endmodule

// [tb/tcmp_timer_sva.sv]
`timescale 1ns/1ps
module tcmp_timer_sva (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic MATCH_IRQ_ACK,
  input wire logic OVF_IRQ_ACK,
  input wire logic MATCH_IRQ,
  input wire logic OVF_IRQ,
  input wire logic PIN_OUT,
  input wire logic PIN_OE
);
  logic wr_acc;
  logic [6:0] ctrl_reg;
  logic [1:0] port_reg;
  logic [2:0] run_reg;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  // Shadow of control and port bits; run_reg stays nonzero shortly after a stop
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      ctrl_reg <= 7'h00;
      port_reg <= 2'h0;
      run_reg <= 3'h0;
    end else begin
      if (wr_acc && PADDR == tcmp_pkg::ADDR_CTRL) begin
        ctrl_reg <= PWDATA[6:0];
      end
      if (wr_acc && PADDR == tcmp_pkg::ADDR_PORT) begin
        port_reg <= PWDATA[1:0];
      end
      run_reg <= (ctrl_reg[6:4] != 3'h0) ? 3'h4 : run_reg - {2'h0, run_reg != 3'h0};
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  property p_ready;
    PSEL && PENABLE |-> PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access phase");
  property p_err;
    PSEL && PENABLE && (PADDR > tcmp_pkg::ADDR_PORT || PADDR[1:0] != 2'h0)
      |-> PSLVERR && (PWRITE || PRDATA == 32'h0);
  endproperty
  a_err: assert property (p_err) else $error("bad unmapped access");
  property p_mask;
    wr_acc && PADDR == tcmp_pkg::ADDR_IRQEN && PWDATA[1:0] == 2'h0 |=> !MATCH_IRQ && !OVF_IRQ;
  endproperty
  a_mask: assert property (p_mask) else $error("irq not masked");
  property p_ovf_ack;
    OVF_IRQ_ACK [*2] |=> !OVF_IRQ || !$past(OVF_IRQ);
  endproperty
  a_ovf_ack: assert property (p_ovf_ack) else $error("ack did not clear");
  property p_oe;
    $past(RESET_N) |-> PIN_OE == port_reg[1];
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_port;
    $past(RESET_N) && $past(ctrl_reg[3:2]) == 2'h0 |-> PIN_OUT == port_reg[0];
  endproperty
  a_port: assert property (p_port) else $error("port data not on pin");
  property p_stop;
    $rose(MATCH_IRQ) |-> run_reg != 3'h0 || $past(wr_acc && PADDR == tcmp_pkg::ADDR_IRQEN);
  endproperty
  a_stop: assert property (p_stop) else $error("match while stopped");
  property p_force;
    wr_acc && PADDR == tcmp_pkg::ADDR_FORCE && PWDATA[0] && run_reg == 3'h0
      && ctrl_reg[6:4] == 3'h0 && !ctrl_reg[0] && ctrl_reg[3:2] != 2'h0
      |-> ##1 (ctrl_reg[3:2] == tcmp_pkg::COM_SET ? PIN_OUT
        : ctrl_reg[3:2] == tcmp_pkg::COM_CLEAR ? !PIN_OUT : PIN_OUT != $past(PIN_OUT));
  endproperty
  a_force: assert property (p_force) else $error("forced output wrong");
  c_ovf: cover property ($rose(OVF_IRQ));
  c_match: cover property ($rose(MATCH_IRQ));
  c_err: cover property (PSEL && PENABLE && PSLVERR);
endmodule
bind tcmp_timer tcmp_timer_sva u_sva (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .MATCH_IRQ_ACK(MATCH_IRQ_ACK),
  .OVF_IRQ_ACK(OVF_IRQ_ACK), .MATCH_IRQ(MATCH_IRQ), .OVF_IRQ(OVF_IRQ), .PIN_OUT(PIN_OUT),
  .PIN_OE(PIN_OE));

// [tb/timer8_compare_normal_ctc_tb.sv]
`timescale 1ns/1ps
module timer8_compare_normal_ctc_tb;
  logic sys_clk, reset_n, psel, penable, pwrite, m_ack, o_ack;
  logic pready, pslverr, m_irq, o_irq, pin_out, pin_oe, pad, p0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  int bad_count, n_tests, k, n;
  logic [11:0] ra [9] = '{tcmp_pkg::ADDR_COMPARE, tcmp_pkg::ADDR_COUNT, tcmp_pkg::ADDR_IRQEN,
    tcmp_pkg::ADDR_IRQEN, tcmp_pkg::ADDR_PORT, tcmp_pkg::ADDR_FLAGS, tcmp_pkg::ADDR_CTRL,
    tcmp_pkg::ADDR_CTRL, 12'h01C};
  logic [31:0] rw [9] = '{32'hFFFFFFFF, 32'hFFFFFFA5, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF,
    32'hFFFFFFFF, 32'h0000000F, 32'h0, 32'h5};
  logic [31:0] rx [9] = '{32'hFF, 32'hA5, 32'h3, 32'h0, 32'h3, 32'h0, 32'hF, 32'h0, 32'h0};
  logic [1:0] fc [3] = '{tcmp_pkg::COM_SET, tcmp_pkg::COM_CLEAR, tcmp_pkg::COM_TOGGLE};
  logic fe [3] = '{1'b1, 1'b0, 1'b1};
  tcmp_timer dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MATCH_IRQ_ACK(m_ack), .OVF_IRQ_ACK(o_ack), .MATCH_IRQ(m_irq),
    .OVF_IRQ(o_irq), .PIN_OUT(pin_out), .PIN_OE(pin_oe));
  tcmp_pin_model pin (.drv(pin_out), .oe(pin_oe), .pad(pad));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] ctl(input logic [2:0] cs, input logic [1:0] com,
      input logic [1:0] wgm);
    return {25'h0, cs, com, wgm};
  endfunction
  task automatic close_out;
    $display("mismatches %0d, checks %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  // Setup, access until ready, release, one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'b1 && t < 16);
    if (pready !== 1'b1) chk(32'h0, 32'h1);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, m_ack, o_ack} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    bad_count = 0;
    n_tests = 0;
    cyc(3);
    reset_n <= 1'b1;
    cyc(1);
    for (int i = 0; i < 7; i++) begin
      rd(12'(4 * i), 32'h0);
    end
    chk({30'h0, pin_oe, pin_out}, 32'h0);
    for (int i = 0; i < 9; i++) begin
      wr(ra[i], rw[i]);
      rd(ra[i], rx[i]);
    end
    // Counter write equal to compare value, then start
    wr(tcmp_pkg::ADDR_COMPARE, 32'h5);
    wr(tcmp_pkg::ADDR_COUNT, 32'h5);
    wr(tcmp_pkg::ADDR_FLAGS, 32'h3);
    wr(tcmp_pkg::ADDR_CTRL, ctl(tcmp_pkg::CS_DIRECT, tcmp_pkg::COM_NONE, tcmp_pkg::WGM_NORMAL));
    cyc(4);
    rd(tcmp_pkg::ADDR_FLAGS, 32'h0);
    wr(tcmp_pkg::ADDR_CTRL, 32'h0);
    // Overflow in normal mode
    wr(tcmp_pkg::ADDR_COMPARE, 32'h80);
    wr(tcmp_pkg::ADDR_COUNT, 32'hFD);
    wr(tcmp_pkg::ADDR_IRQEN, 32'h2);
    wr(tcmp_pkg::ADDR_CTRL, ctl(tcmp_pkg::CS_DIRECT, tcmp_pkg::COM_NONE, tcmp_pkg::WGM_NORMAL));
    for (k = 0; o_irq !== 1'b1 && k < 20; k++) cyc(1);
    wr(tcmp_pkg::ADDR_CTRL, 32'h0);
    chk({31'h0, o_irq}, 32'h1);
    wr(tcmp_pkg::ADDR_FLAGS, 32'h0);
    rd(tcmp_pkg::ADDR_FLAGS, 32'h2);
    o_ack <= 1'b1;
    cyc(2);
    o_ack <= 1'b0;
    cyc(1);
    chk({31'h0, o_irq}, 32'h0);
    // Compare match, partial clear, acknowledge
    wr(tcmp_pkg::ADDR_IRQEN, 32'h1);
    wr(tcmp_pkg::ADDR_COUNT, 32'h7C);
    wr(tcmp_pkg::ADDR_CTRL, ctl(tcmp_pkg::CS_DIRECT, tcmp_pkg::COM_NONE, tcmp_pkg::WGM_NORMAL));
    for (k = 0; m_irq !== 1'b1 && k < 20; k++) cyc(1);
    wr(tcmp_pkg::ADDR_CTRL, 32'h0);
    chk({31'h0, m_irq}, 32'h1);
    wr(tcmp_pkg::ADDR_FLAGS, 32'h2);
    rd(tcmp_pkg::ADDR_FLAGS, 32'h1);
    m_ack <= 1'b1;
    cyc(1);
    m_ack <= 1'b0;
    cyc(1);
    chk({31'h0, m_irq}, 32'h0);
    // Toggle half period equals one plus compare value
    for (int c = 0; c < 4; c += 1 + c) begin
      wr(tcmp_pkg::ADDR_CTRL, 32'h0);
      wr(tcmp_pkg::ADDR_COUNT, 32'h0);
      wr(tcmp_pkg::ADDR_COMPARE, 32'(c));
      wr(tcmp_pkg::ADDR_CTRL, ctl(tcmp_pkg::CS_DIRECT, tcmp_pkg::COM_TOGGLE,
        tcmp_pkg::WGM_CLEAR));
      // First change may be the switch from port data, so skip two changes
      for (int s = 0; s < 2; s++) begin
        p0 = pin_out;
        for (k = 0; pin_out === p0 && k < 40; k++) cyc(1);
      end
      p0 = pin_out;
      for (n = 0; pin_out === p0 && n < 40; n++) cyc(1);
      chk(32'(n), 32'(c + 1));
    end
    // Compare value below count in clear mode
    wr(tcmp_pkg::ADDR_CTRL, 32'h0);
    wr(tcmp_pkg::ADDR_COMPARE, 32'h2);
    wr(tcmp_pkg::ADDR_COUNT, 32'h10);
    wr(tcmp_pkg::ADDR_CTRL, ctl(tcmp_pkg::CS_DIRECT, tcmp_pkg::COM_NONE, tcmp_pkg::WGM_CLEAR));
    cyc(2);
    wr(tcmp_pkg::ADDR_CTRL, 32'h0);
    apb(1'b0, tcmp_pkg::ADDR_COUNT, 32'h0);
    chk({31'h0, rdv[7:0] > 8'h10}, 32'h1);
    // Force strobe per output mode, pin released
    wr(tcmp_pkg::ADDR_PORT, 32'h0);
    wr(tcmp_pkg::ADDR_FLAGS, 32'h3);
    for (int j = 0; j < 3; j++) begin
      wr(tcmp_pkg::ADDR_CTRL, ctl(tcmp_pkg::CS_STOP, fc[j], tcmp_pkg::WGM_NORMAL));
      wr(tcmp_pkg::ADDR_FORCE, 32'h1);
      cyc(2);
      chk({31'h0, pin_out}, {31'h0, fe[j]});
    end
    wr(tcmp_pkg::ADDR_PORT, 32'h2);
    cyc(2);
    chk({31'h0, pad}, 32'h1);
    wr(tcmp_pkg::ADDR_CTRL, ctl(tcmp_pkg::CS_STOP, tcmp_pkg::COM_TOGGLE, tcmp_pkg::WGM_FAST));
    cyc(2);
    chk({31'h0, pin_out}, 32'h1);
    wr(tcmp_pkg::ADDR_CTRL, 32'h0);
    cyc(2);
    chk({31'h0, pad}, 32'h0);
    rd(tcmp_pkg::ADDR_FLAGS, 32'h0);
    rd(tcmp_pkg::ADDR_PORT, 32'h6);
    // Reset with the timer stopped and the pin driven returns pin and port state to idle
    reset_n <= 1'b0;
    cyc(2);
    reset_n <= 1'b1;
    cyc(1);
    chk({30'h0, pin_oe, pin_out}, 32'h0);
    rd(tcmp_pkg::ADDR_PORT, 32'h0);
    close_out();
  end
endmodule
